/* File: serial_peer.sv */
// behavioural synchronous serial partner: frames in external mode, captures the data pin
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
  input wire logic sck_i,
  input wire logic txd_i,
  output logic sck_o,
  output logic rxd_o
);
  logic [7:0] sh;
  int n;
  realtime last;
  realtime longest;
  logic [7:0] got[$];
  // clock line rests high between frames
  initial begin
    sck_o = 1'b1;
    rxd_o = 1'b0;
  end
  // forget captured bytes and pulse counts
  task automatic clear();
    n = 0;
    last = 0;
    longest = 0;
    got.delete();
  endtask : clear
  // sample at each rising clock, lsb first; widest rise spacing shows gaps
  always @(posedge sck_i) begin
    sh = {txd_i, sh[7:1]};
    n = n + 1;
    if (last > 0 && $realtime - last > longest) begin
      longest = $realtime - last;
    end
    last = $realtime;
    if (n % 8 == 0) begin
      got.push_back(sh);
    end
  end
  // one frame of eight pulses; data changes on falling edges
  task automatic frame(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      sck_o = 1'b0;
      rxd_o = b[i];
      #62.5;
      sck_o = 1'b1;
      #62.5;
    end
    rxd_o = ~rxd_o; // line driven to the opposite level after the frame, so no stale level
  endtask : frame
endmodule : serial_peer
`default_nettype wire

/* File: sync_serial_txrx.sv */
// synchronous serial transmitter and receiver with ahb-lite registers
`timescale 1ns/1ps
`default_nettype none
`include "sync_serial_txrx_cfg.svh"
module sync_serial_txrx (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic [31:0] hrdata_o,
  output logic hresp_o,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_o,
  input wire logic rxd_i,
  output logic txd_o,
  output logic tx_end_irq_o,
  output logic rx_error_irq_o,
  output logic rx_full_irq_o,
  output logic tx_empty_irq_o,
  output logic [2:0] irq_prio_o
);
  sync_serial_txrx_pkg::state_t r;
  sync_serial_txrx_pkg::state_t n;
  logic err, want, load_ok, ahb_go, ctl_wr, st_wr, tb_wr;
  logic sck_nv, rxd_nv, itog, fall_ev, rise_ev;

  // level after three flops: new value only once second and third agree
  function automatic logic filt(input logic [2:0] s, input logic lv);
    filt = (s[1] == s[2]) ? s[2] : lv;
  endfunction : filt

  // status byte image, used for reads and for the read-as-one record
  function automatic logic [7:0] stat(input sync_serial_txrx_pkg::state_t s);
    stat = 8'h00;
    stat[`ST_TX_BUFFER_EMPTY_FLAG] = s.tx_buffer_empty_flag;
    stat[`ST_RX_FULL_FLAG] = s.rx_full_flag;
    stat[`ST_OVERRUN_FLAG] = s.overrun_flag;
    stat[`ST_FER] = s.framing_error_flag;
    stat[`ST_PER] = s.per;
    stat[`ST_TX_END_FLAG] = s.tx_end_flag;
  endfunction : stat

  // written 0 clears only a flag that was read as 1
  function automatic logic clr(input logic f, input logic seen, input logic w);
    clr = f & ~(seen & ~w);
  endfunction : clr

  // event decode shared by generator, transmitter and receiver
  assign err = r.overrun_flag | r.framing_error_flag | r.per;
  assign want = r.tbusy | (r.re & ~err);
  assign sck_nv = filt(r.sck_s, r.sck_lv);
  assign rxd_nv = filt(r.rxd_s, r.rxd_lv);
  assign itog = ~r.ext & r.run & (r.hcnt == `SCK_HALF_CYC - 8'h01);
  assign fall_ev = r.ext ? (r.sck_lv & ~sck_nv) : (itog & r.sck);
  assign rise_ev = r.ext ? (~r.sck_lv & sck_nv) : (itog & ~r.sck);
  // internal clock: a new character only starts at a frame boundary
  assign load_ok = r.ext | ~r.run | (rise_ev & (r.pcnt == `LAST_BIT));
  assign ahb_go = hsel_i & htrans_i[1] & hready_i;
  assign ctl_wr = r.dph_w & (r.waddr == `CTRL_OFS);
  assign st_wr = r.dph_w & (r.waddr == `STAT_OFS);
  assign tb_wr = r.dph_w & (r.waddr == `TBUF_OFS);

  // next state of the whole block
  always_comb begin
    n = r;
    n.sck_s = {r.sck_s[1:0], sck_i};
    n.rxd_s = {r.rxd_s[1:0], rxd_i};
    n.sck_lv = sck_nv;
    n.rxd_lv = rxd_nv;
    // software clears come first so that hardware sets below win
    if (st_wr) begin
      n.tx_buffer_empty_flag = clr(r.tx_buffer_empty_flag, r.seen[`ST_TX_BUFFER_EMPTY_FLAG], hwdata_i[`ST_TX_BUFFER_EMPTY_FLAG]);
      n.tx_end_flag = clr(r.tx_end_flag, r.seen[`ST_TX_END_FLAG], hwdata_i[`ST_TX_END_FLAG]);
      n.rx_full_flag = clr(r.rx_full_flag, r.seen[`ST_RX_FULL_FLAG], hwdata_i[`ST_RX_FULL_FLAG]);
      n.overrun_flag = clr(r.overrun_flag, r.seen[`ST_OVERRUN_FLAG], hwdata_i[`ST_OVERRUN_FLAG]);
      n.framing_error_flag = clr(r.framing_error_flag, r.seen[`ST_FER], hwdata_i[`ST_FER]);
      n.per = clr(r.per, r.seen[`ST_PER], hwdata_i[`ST_PER]);
      n.seen = 8'h00;
    end
    if (tb_wr) begin
      n.tbuf = hwdata_i[7:0];
    end
    // address phase: zero wait, read data captured now for the data phase
    n.dph_w = ahb_go & hwrite_i & (hsize_i == `SIZE_WORD);
    n.waddr = (haddr_i[31:8] == 24'h000000) ? haddr_i[7:0] : `NO_REG;
    if (ahb_go & ~hwrite_i) begin
      n.rdata = 32'h00000000;
      case (n.waddr)
        `CTRL_OFS: begin
          n.rdata[5:0] = {r.ext, r.tx_end_irq_enable, r.rx_irq_enable, r.tx_empty_irq_enable, r.re, r.te};
        end
        `STAT_OFS: begin
          n.rdata[7:0] = stat(r);
          n.seen = n.seen | stat(r);
        end
        `TBUF_OFS: n.rdata[7:0] = r.tbuf;
        `RBUF_OFS: n.rdata[7:0] = r.rbuf;
        default: n.rdata = 32'h00000000;
      endcase
    end
    // internal clock generator: eight pulses per character, idle high
    if (~r.ext) begin
      if (!r.run) begin
        n.sck = `SCK_IDLE;
        if (want) begin
          n.run = 1'b1;
          n.hcnt = 8'h00;
          n.pcnt = 4'h0;
          n.rcnt = 4'h0;
        end
      end else if (itog) begin
        n.hcnt = 8'h00;
        n.sck = ~r.sck;
        if (~r.sck) begin
          n.pcnt = r.pcnt + 4'h1;
          if (r.pcnt == `LAST_BIT) begin
            n.pcnt = 4'h0;
            n.run = want;
          end
        end
      end else begin
        n.hcnt = r.hcnt + 8'h01;
      end
    end else begin
      // partner drives the clock; receiver restarts while disabled
      n.run = 1'b0;
      n.sck = `SCK_IDLE;
      if (!r.re) begin
        n.rcnt = 4'h0;
      end
    end
    // transmitter: load on cleared empty flag, shift on falling edges
    if (~r.tbusy & r.te & ~r.tx_buffer_empty_flag & ~err & load_ok) begin
      n.tsh = r.tbuf;
      n.tx_buffer_empty_flag = 1'b1;
      n.tbusy = 1'b1;
      n.tcnt = 4'h0;
      n.tx_end_flag = 1'b0;
    end else if (fall_ev & r.tbusy) begin
      n.txd = r.tsh[0];
      n.tsh = {1'b0, r.tsh[7:1]};
      n.tcnt = r.tcnt + 4'h1;
      if (r.tcnt == `LAST_BIT) begin
        if (~r.tx_buffer_empty_flag & r.te & ~err) begin
          n.tsh = r.tbuf;
          n.tx_buffer_empty_flag = 1'b1;
          n.tcnt = 4'h0;
        end else begin
          n.tbusy = 1'b0;
          n.tx_end_flag = 1'b1;
        end
      end
    end
    // receiver: sample on rising edges, store or flag overrun
    if (rise_ev & r.re & ~err) begin
      n.rsh = {r.rxd_lv, r.rsh[7:1]};
      n.rcnt = r.rcnt + 4'h1;
      if (r.rcnt == `LAST_BIT) begin
        n.rcnt = 4'h0;
        if (~r.rx_full_flag) begin
          n.rbuf = {r.rxd_lv, r.rsh[7:1]};
          n.rx_full_flag = 1'b1;
        end else begin
          n.overrun_flag = 1'b1;
        end
      end
    end
    // control write last: clearing transmit enable beats any load
    if (ctl_wr) begin
      n.te = hwdata_i[`CTL_TE];
      n.re = hwdata_i[`CTL_RE];
      n.tx_empty_irq_enable = hwdata_i[`CTL_TIE];
      n.rx_irq_enable = hwdata_i[`CTL_RIE];
      n.tx_end_irq_enable = hwdata_i[`CTL_TX_END_IRQ_ENABLE];
      n.ext = hwdata_i[`CTL_EXT];
      n.oe = ~hwdata_i[`CTL_EXT];
      if (!hwdata_i[`CTL_TE]) begin
        n.tx_buffer_empty_flag = 1'b1;
        n.tbusy = 1'b0;
        n.tsh = 8'h00;
        n.tcnt = 4'h0;
      end
    end
    // four separate request lines and the highest pending one
    n.irq[`IRQ_ERR] = n.rx_irq_enable & (n.overrun_flag | n.framing_error_flag | n.per);
    n.irq[`IRQ_RXF] = n.rx_irq_enable & n.rx_full_flag;
    n.irq[`IRQ_TXE] = n.tx_empty_irq_enable & n.tx_buffer_empty_flag;
    n.irq[`IRQ_TX_END_FLAG] = n.tx_end_irq_enable & n.tx_end_flag;
    if (n.irq[`IRQ_ERR]) n.prio = sync_serial_txrx_pkg::PRIO_ERR;
    else if (n.irq[`IRQ_RXF]) n.prio = sync_serial_txrx_pkg::PRIO_RXF;
    else if (n.irq[`IRQ_TXE]) n.prio = sync_serial_txrx_pkg::PRIO_TXE;
    else if (n.irq[`IRQ_TX_END_FLAG]) n.prio = sync_serial_txrx_pkg::PRIO_TX_END_FLAG;
    else n.prio = sync_serial_txrx_pkg::PRIO_NONE;
  end

  // single state register, synchronous reset
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      r <= '0;
      r.tx_buffer_empty_flag <= `TX_BUFFER_EMPTY_FLAG_RST;
      r.tx_end_flag <= `TX_END_FLAG_RST;
      r.sck <= `SCK_IDLE;
      r.txd <= `TXD_RST;
      r.oe <= 1'b1;
      r.sck_s <= `SYNC_RST;
      r.sck_lv <= `SCK_IDLE;
      r.rdy <= 1'b1;
      r.waddr <= `NO_REG;
    end else begin
      r <= n;
    end
  end

  // every output straight from the state register
  assign hreadyout_o = r.rdy;
  assign hrdata_o = r.rdata;
  assign hresp_o = r.resp;
  assign sck_o = r.sck;
  assign sck_oe_o = r.oe;
  assign txd_o = r.txd;
  assign tx_end_irq_o = r.irq[`IRQ_TX_END_FLAG];
  assign rx_error_irq_o = r.irq[`IRQ_ERR];
  assign rx_full_irq_o = r.irq[`IRQ_RXF];
  assign tx_empty_irq_o = r.irq[`IRQ_TXE];
  assign irq_prio_o = r.prio;

  // checks on the block's own behaviour
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  a_buffer_load: assert property (
    (!r.tbusy && r.te && !r.tx_buffer_empty_flag && !err && load_ok && !ctl_wr)
    |=> (r.tbusy && r.tx_buffer_empty_flag && r.tcnt == 4'h0 && r.tsh == $past(r.tbuf)))
    else $error("buffer not loaded after empty flag cleared");
  a_clock_stops: assert property (
    $fell(r.run) && !$past(r.ext) |-> ($past(r.pcnt) == 4'h7 && r.sck))
    else $error("clock stopped off a character boundary");
  a_lsb_first: assert property (
    (fall_ev && r.tbusy && !ctl_wr) |=> (r.txd == $past(r.tsh[0])))
    else $error("transmit bit order wrong");
  a_bit7_reload: assert property (
    (fall_ev && r.tbusy && r.tcnt == 4'h7 && !r.tx_buffer_empty_flag && r.te && !err && !ctl_wr)
    |=> (r.tbusy && r.tx_buffer_empty_flag && r.tcnt == 4'h0))
    else $error("no seamless reload at bit 7");
  a_end_hold: assert property (
    (fall_ev && r.tbusy && r.tcnt == 4'h7 && r.tx_buffer_empty_flag && !ctl_wr)
    |=> (r.tx_end_flag && !r.tbusy) ##1 (r.txd == $past(r.txd)))
    else $error("end flag or data hold wrong");
  a_idle_high: assert property (
    (!r.run && !r.ext) |=> r.sck)
    else $error("serial clock not high when idle");
  a_rx_store: assert property (
    (rise_ev && r.re && !err && r.rcnt == 4'h7 && !r.rx_full_flag)
    |=> (r.rx_full_flag && r.rbuf == $past({r.rxd_lv, r.rsh[7:1]})) ##1 (rx_full_irq_o == r.rx_irq_enable))
    else $error("received character not stored");
  a_overrun_keep: assert property (
    (rise_ev && r.re && !err && r.rcnt == 4'h7 && r.rx_full_flag) |=> (r.overrun_flag && $stable(r.rbuf)))
    else $error("overrun handling wrong");
  a_error_blocks: assert property (
    (err && !r.tbusy) |=> !r.tbusy)
    else $error("transmission started despite error");
  a_te_clear: assert property (
    (ctl_wr && !hwdata_i[`CTL_TE]) |=> (r.tx_buffer_empty_flag && !r.tbusy && r.tsh == 8'h00))
    else $error("transmit disable did not reset");
  a_error_irq: assert property (
    rx_error_irq_o == (r.rx_irq_enable && err))
    else $error("error request mismatch");
  a_priority: assert property (
    rx_error_irq_o |-> irq_prio_o == 3'h4)
    else $error("error request not on top");


  // each request line is the plain level of flag and enable
  a_rx_full_irq: assert property (
    rx_full_irq_o == (r.rx_irq_enable && r.rx_full_flag))
    else $error("receive full request mismatch");
  a_tx_empty_irq: assert property (
    tx_empty_irq_o == (r.tx_empty_irq_enable && r.tx_buffer_empty_flag))
    else $error("transmit empty request mismatch");
  a_tx_end_irq: assert property (
    tx_end_irq_o == (r.tx_end_irq_enable && r.tx_end_flag))
    else $error("transmit end request mismatch");

  // lower levels of the fixed priority order
  a_prio_rxf: assert property (
    (rx_full_irq_o && !rx_error_irq_o) |-> irq_prio_o == 3'h3)
    else $error("receive full priority wrong");
  a_prio_txe: assert property (
    (tx_empty_irq_o && !rx_full_irq_o && !rx_error_irq_o) |-> irq_prio_o == 3'h2)
    else $error("transmit empty priority wrong");
  a_prio_tx_end_flag: assert property (
    (tx_end_irq_o && !tx_empty_irq_o && !rx_full_irq_o && !rx_error_irq_o) |-> irq_prio_o == 3'h1)
    else $error("transmit end priority wrong");

  // pin direction follows the clock source
  a_ext_clock_in: assert property (
    r.ext |-> !sck_oe_o)
    else $error("clock driven in external mode");
  a_int_clock_out: assert property (
    !r.ext |-> sck_oe_o)
    else $error("clock not driven in internal mode");

  // an error flag freezes the receiver until software clears it
  a_err_holds_rx: assert property (
    err |=> $stable(r.rsh))
    else $error("receiver shifted during error");
  a_err_no_full: assert property (
    (err && !r.rx_full_flag) |=> !r.rx_full_flag)
    else $error("full flag set during error");

  // counters never run past eight bits of a character
  a_tx_count: assert property (
    r.tbusy |-> r.tcnt <= 4'h7)
    else $error("transmit count out of range");
  a_rx_count: assert property (
    r.rcnt <= 4'h7)
    else $error("receive count out of range");
  a_pulse_count: assert property (
    r.pcnt <= 4'h7)
    else $error("pulse count out of range");

  // data pin and buffer move only on their own events
  a_txd_steady: assert property (
    !fall_ev |=> $stable(r.txd))
    else $error("data pin moved off a falling edge");
  a_rbuf_steady: assert property (
    !(rise_ev && r.re && !err && r.rcnt == 4'h7 && !r.rx_full_flag) |=> $stable(r.rbuf))
    else $error("receive buffer changed without a stored character");

  c_continuous_tx: cover property (fall_ev && r.tbusy && r.tcnt == 4'h7 && !r.tx_buffer_empty_flag);
  c_error_cleared: cover property ($fell(r.overrun_flag));
  c_rx_store: cover property (rise_ev && r.re && r.rcnt == 4'h7 && !r.rx_full_flag);
  c_overrun: cover property ($rose(r.overrun_flag));
  c_ext_end: cover property (r.ext && $rose(r.tx_end_flag));
endmodule : sync_serial_txrx
`default_nettype wire

/* File: sync_serial_txrx_cfg.svh */
// offsets, field positions, reset values and timing counts of the synchronous serial unit
// Function
// - clearing the empty flag makes the unit load the transmit buffer into the shifter
// - after loading, empty flag returns to 1, shifting starts, empty interrupt if enabled
// - internal clock drives exactly eight serial clock pulses per character
// - external clock source: partner supplies clock, transmit data follows it
// - transmit bits leave least significant first, bit 0 to bit 7
// - at bit 7, empty flag 0 means reload and continue without gap
// - at bit 7, empty flag 1 sets end flag; data pin holds bit 7 level
// - serial clock pin rests high after transmission ends; internal clock runs on while receive is enabled and no error
// - parity or framing error blocks receive-full setting, receive shifting and new transmit loads
// - overrun flag set blocks transmit and receive until software clears it
// - receive bits enter LSB first; full character stored when full flag is 0
// - full flag still set at character end gives error state blocking transfers
// - receive-full interrupt follows full flag when receive interrupt enabled
// - overrun with receive interrupt enabled raises the receive-error interrupt
// - receiver aligns to the serial clock and resets its count at start
// - four interrupt sources, each on its own request line
// - error interrupt from overrun, framing or parity; end interrupt from end flag
// - priority after reset: error, receive full, transmit empty, transmit end
// - overrun keeps receive buffer and drops the shifted character
// - any receive error flag stops a new transmission from starting
// - clearing transmit enable sets empty flag and resets transmit shifter
// - characters are eight data bits, no parity, no extra bit
`ifndef SYNC_SERIAL_TXRX_CFG_SVH
`define SYNC_SERIAL_TXRX_CFG_SVH
`define CTRL_OFS 8'h00
`define STAT_OFS 8'h04
`define TBUF_OFS 8'h08
`define RBUF_OFS 8'h0c
`define NO_REG 8'hff
`define CTL_TE 0
`define CTL_RE 1
`define CTL_TIE 2
`define CTL_RIE 3
`define CTL_TX_END_IRQ_ENABLE 4
`define CTL_EXT 5
`define ST_TX_END_FLAG 2
`define ST_PER 3
`define ST_FER 4
`define ST_OVERRUN_FLAG 5
`define ST_RX_FULL_FLAG 6
`define ST_TX_BUFFER_EMPTY_FLAG 7
`define IRQ_TX_END_FLAG 0
`define IRQ_TXE 1
`define IRQ_RXF 2
`define IRQ_ERR 3
`define TX_BUFFER_EMPTY_FLAG_RST 1'b1
`define TX_END_FLAG_RST 1'b1
`define SCK_IDLE 1'b1
`define TXD_RST 1'b1
`define SYNC_RST 3'h7
`define SIZE_WORD 3'h2
`define LAST_BIT 4'h7
`define CLK_NS 10
`define SCK_HALF_NS 40
`define SCK_HALF_CYC 8'(((`SCK_HALF_NS) + (`CLK_NS) - 1) / (`CLK_NS))
`endif

/* File: sync_serial_txrx_pkg.sv */
// types of the synchronous serial unit
`default_nettype none
package sync_serial_txrx_pkg;
  typedef enum logic [2:0] {PRIO_NONE, PRIO_TX_END_FLAG, PRIO_TXE, PRIO_RXF, PRIO_ERR} prio_t;
  typedef struct packed {
    logic te, re, tx_empty_irq_enable, rx_irq_enable, tx_end_irq_enable, ext, oe;
    logic tx_buffer_empty_flag, tx_end_flag, rx_full_flag, overrun_flag, framing_error_flag, per;
    logic [7:0] seen;
    logic [7:0] tbuf, tsh, rbuf, rsh;
    logic [3:0] tcnt, rcnt, pcnt;
    logic tbusy, txd, run, sck;
    logic [7:0] hcnt;
    logic [2:0] sck_s, rxd_s;
    logic sck_lv, rxd_lv;
    logic dph_w, rdy, resp;
    logic [7:0] waddr;
    logic [31:0] rdata;
    logic [3:0] irq;
    prio_t prio;
  } state_t;
endpackage : sync_serial_txrx_pkg
`default_nettype wire

/* File: sync_serial_txrx_tb.sv */
// self-checking bench of the synchronous serial unit
`timescale 1ns/1ps
`default_nettype none
`include "sync_serial_txrx_cfg.svh"
module sync_serial_txrx_tb;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [2:0] hsize_i = 3'h2;
  logic [31:0] hwdata_i = 32'h0;
  logic hready_i, hreadyout_o, hresp_o, sck_i, sck_o, sck_oe_o, rxd_i, txd_o, peer_sck;
  logic tx_end_irq_o, rx_error_irq_o, rx_full_irq_o, tx_empty_irq_o;
  logic [31:0] hrdata_o, s;
  logic [2:0] irq_prio_o;
  logic [7:0] b0, b1, r[4];
  int seed, i, cycles, miscompares, num_checks;
  int m_tx_buffer_empty_flag = 1, m_rx_full_flag = 0, m_overrun_flag = 0;
  logic [7:0] m_rbuf = 8'h00;
  assign hready_i = hreadyout_o;
  assign sck_i = sck_oe_o ? sck_o : peer_sck;
  sync_serial_txrx dut (.clk_sys_i, .resetn_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i,
    .hwdata_i, .hready_i, .hreadyout_o, .hrdata_o, .hresp_o, .sck_i, .sck_o, .sck_oe_o, .rxd_i,
    .txd_o, .tx_end_irq_o, .rx_error_irq_o, .rx_full_irq_o, .tx_empty_irq_o, .irq_prio_o);
  serial_peer peer (.sck_i(sck_i), .txd_i(txd_o), .sck_o(peer_sck), .rxd_o(rxd_i));
  // 100 MHz clock
  always #5 clk_sys_i = ~clk_sys_i;
  // hang guard
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one single ahb transfer; waits on hready, never on a fixed count
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_sys_i);
    hsel_i <= 1'b1;
    haddr_i <= a;
    htrans_i <= 2'h2;
    hwrite_i <= wr;
    hsize_i <= wr ? `SIZE_WORD : 3'($random(seed));
    do @(posedge clk_sys_i); while (hready_i !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= wr ? wd : 32'($random(seed));
    do @(posedge clk_sys_i); while (hready_i !== 1'b1);
    rd = hrdata_o;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, {24'h0, a}, d, x);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    xfer(1'b0, {24'h0, a}, 32'h0, d);
  endtask : rd
  // model of a received character: error blocks, full flag gives overrun
  function automatic void m_rx(input logic [7:0] b);
    if (m_overrun_flag == 0 && m_rx_full_flag == 1) m_overrun_flag = 1;
    else if (m_overrun_flag == 0) begin
      m_rbuf = b;
      m_rx_full_flag = 1;
    end
  endfunction : m_rx
  task automatic chk_stat();
    logic [31:0] v;
    rd(`STAT_OFS, v);
    chk("stat", {24'h0, m_tx_buffer_empty_flag[0], m_rx_full_flag[0], m_overrun_flag[0], 5'h0}, v & 32'hf8);
    rd(`RBUF_OFS, v);
    chk("rbuf", {24'h0, m_rbuf}, v);
  endtask : chk_stat
  // status read, buffer write, then only the empty flag written 0
  task automatic send(input logic [7:0] b);
    logic [31:0] v;
    rd(`STAT_OFS, v);
    chk("tx_buffer_empty_flag", 32'h1, v[`ST_TX_BUFFER_EMPTY_FLAG]);
    wr(`TBUF_OFS, {24'h0, b});
    wr(`STAT_OFS, 32'h7f);
  endtask : send
  task automatic tally_and_finish();
    if (miscompares == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish
  // main sequence
  initial begin
    seed = 37702;
    repeat (10) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    rd(`STAT_OFS, s);
    chk("stat_rst", 32'h84, s);
    chk("pins_rst", 11'h700, {sck_o, sck_oe_o, txd_o, hresp_o, tx_end_irq_o, rx_error_irq_o,
      rx_full_irq_o, tx_empty_irq_o, irq_prio_o});
    xfer(1'b1, 32'h100, 32'h3f, s);
    wr(8'h10, 32'h3f);
    rd(8'h10, s);
    chk("unmapped", 32'h0, s);
    rd(`CTRL_OFS, s);
    chk("ctrl", 32'h0, s);
    // internal clock, two characters back to back
    wr(`CTRL_OFS, 32'h15);
    peer.clear();
    b0 = 8'($random(seed));
    b1 = 8'($random(seed));
    send(b0);
    send(b1);
    for (i = 0; i < 4000 && peer.got.size() < 2; i++) @(posedge clk_sys_i);
    repeat (8) @(posedge clk_sys_i);
    chk("tx_bytes", {b0, b1}, {peer.got[0], peer.got[1]});
    chk("pulses", 32'd16, peer.n);
    chk("gap_ns", 32'd80, int'(peer.longest));
    chk("idle", {1'b1, b1[7], 1'b1, 1'b1, 3'h2},
      {sck_o, txd_o, tx_end_irq_o, tx_empty_irq_o, irq_prio_o});
    rd(`STAT_OFS, s);
    chk("tx_end_flag", 32'h1, s[`ST_TX_END_FLAG]);
    // external clock, full duplex, then overrun and recovery
    wr(`CTRL_OFS, 32'h2b);
    peer.clear();
    for (i = 0; i < 4; i++) r[i] = 8'($random(seed));
    send(b0);
    chk("oe", 32'h0, sck_oe_o);
    peer.frame(r[0]);
    m_rx(r[0]);
    for (i = 0; i < 100 && rx_full_irq_o !== 1'b1; i++) @(posedge clk_sys_i);
    chk("irq_rx", 5'h0b, {rx_error_irq_o, rx_full_irq_o, irq_prio_o});
    chk_stat();
    chk("tx_ext", b0, peer.got[0]);
    peer.frame(r[1]);
    m_rx(r[1]);
    for (i = 0; i < 100 && rx_error_irq_o !== 1'b1; i++) @(posedge clk_sys_i);
    chk("irq_err", 5'h1c, {rx_error_irq_o, rx_full_irq_o, irq_prio_o});
    chk_stat();
    send(b1);
    m_tx_buffer_empty_flag = 0;
    chk_stat();
    peer.frame(r[2]);
    m_rx(r[2]);
    chk("tx_held", {8{b0[7]}}, peer.got[2]);
    chk_stat();
    // a status write forgets earlier reads, so the zeros below must clear nothing
    wr(`STAT_OFS, 32'hff);
    wr(`STAT_OFS, 32'h0);
    chk_stat();
    wr(`CTRL_OFS, 32'h2a);
    m_tx_buffer_empty_flag = 1;
    chk_stat();
    wr(`STAT_OFS, 32'h9f);
    m_rx_full_flag = 0;
    m_overrun_flag = 0;
    chk_stat();
    chk("err_off", 32'h0, rx_error_irq_o);
    peer.frame(r[3]);
    m_rx(r[3]);
    for (i = 0; i < 100 && rx_full_irq_o !== 1'b1; i++) @(posedge clk_sys_i);
    chk_stat();
    tally_and_finish();
  end
endmodule : sync_serial_txrx_tb
`default_nettype wire
